/* bench/test_trig_front.sv */
// self-checking bench of the trigger front end
`timescale 1ns/1ps
`include "trig_params.svh"
module test_trig_front
	import trig_pkg::*;
;
	logic        sys_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        ext_lvl = 1'b0, ecl = 1'b0, marker = 1'b1, mk_prev = 1'b1;
	logic        mk_rand = 1'b0, mk_chk = 1'b0, tm, den;
	logic [7:0]  addr = 8'h00, bp_drv = 8'hFF, ttl_in, ttl_out, ttl_oe;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0]  lag = 4'h2;
	logic        int_clk, cycle_done, start, running, sync_out;
	integer      seed = 32'hC6F3;
	int          num_errors = 0, checked = 0, exp_cnt = 0, i, v;
	logic [39:0] rst_tab [10] = '{{`ADDR_CTRL, 32'(`RST_CTRL)}, {`ADDR_TTL_IN, 32'(`RST_TTL_IN)},
		{`ADDR_TTL_OUT, 32'(`RST_TTL_OUT)}, {`ADDR_INT_PERIOD, 32'(`RST_INT_PERIOD)},
		{`ADDR_DLY_CYC, 32'(`RST_DLY_CYC)}, {`ADDR_DLY_TIME, `RST_DLY_TIME},
		{`ADDR_CMD, 32'h0}, {`ADDR_TRIG_CNT, 32'h0}, {8'h24, 32'h0},
		{`ADDR_STATUS, 32'h84}}; // status: idle state bit and marker high

	always #20 sys_clk = ~sys_clk;

	trig_front DUT (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_trig_i(ext_lvl), .ecl_trig_i(ecl),
		.ttl_i(ttl_in), .int_clk_i(int_clk), .marker_i(marker), .cycle_done_i(cycle_done),
		.start_o(start), .running_o(running), .ttl_o(ttl_out), .ttl_oe_o(ttl_oe),
		.sync_out_o(sync_out));
	trig_partner far (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .bp_drv_i(bp_drv),
		.dut_ttl_i(ttl_out), .dut_oe_i(ttl_oe), .running_i(running), .lag_i(lag),
		.ttl_o(ttl_in), .int_clk_o(int_clk), .cycle_done_o(cycle_done));

	// ======================================================================
	// marker source and its copy on every backplane line and the front output
	always @(posedge sys_clk) begin
		mk_prev <= marker;
		marker  <= mk_rand ? 1'($random(seed)) : 1'b1;
	end
	always @(negedge sys_clk)
		if (mk_chk) check("marker copy", {23'h0, ttl_out, sync_out}, {23'h0, {9{mk_prev}}});

	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] want);
		checked++;
		if (got !== want) begin
			$display("FAIL %s expected %h seen %h", nm, want, got);
			num_errors++;
		end
	endtask : check

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// ======================================================================
	// register port: one-cycle strobes, read data in the following cycle only
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] dt);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= dt;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] dt);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		dt = rdata;
	endtask : rd_reg

	// pin 0 front panel, 1 ECL line, 2..9 backplane lines 0..7
	task automatic pin(input int p, input logic lv);
		@(posedge sys_clk);
		if (p == 0)
			ext_lvl <= lv;
		else if (p == 1)
			ecl <= lv;
		else
			bp_drv[p-2] <= lv;
	endtask : pin

	// want: -1 no start in 20 cycles, -2 a start within 60 cycles, else exact cycle of start
	task automatic expect_start(input string nm, input int want);
		int n;
		int lim;
		n = -1;
		lim = (want == -1) ? 20 : 60;
		for (int k = 0; k < lim && n < 0; k++) begin
			@(negedge sys_clk);
			if (start === 1'b1)
				n = k;
		end
		if (want == -2)
			check(nm, n >= 0, 1);
		else
			check(nm, n, want);
		if (n >= 0) begin
			exp_cnt++;
			check({nm, " running"}, running, 1);
			for (int k = 0; k < 40 && running !== 1'b0; k++)
				@(negedge sys_clk);
			check({nm, " idle"}, running, 0);
		end
		if ((want != -1 && n < 0) || running !== 1'b0)
			summarize();
	endtask : expect_start

	// cycles from the command to start: a minimum of 100 ns once enabled
	function automatic int dly_cyc(input logic en, input logic t_mode, input int val);
		int t;
		t = t_mode ? val * 20 : val * 40;
		if (t < 100)
			t = 100;
		return en ? (t + 39) / 40 : 0;
	endfunction : dly_cyc

	function automatic logic [31:0] ctrl(input logic [1:0] src, input logic neg, en, t_mode);
		return {26'h0, 1'b1, t_mode, en, neg, src};
	endfunction : ctrl

	// ======================================================================
	// main sequence
	initial begin
		repeat (10) @(negedge sys_clk);
		check("outputs in reset", {start, running, ttl_oe, ttl_out, sync_out}, 0);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		foreach (rst_tab[k]) begin
			rd_reg(rst_tab[k][39:32], d);
			check("reset value", d, rst_tab[k][31:0]);
		end
		mk_chk = 1'b1;
		d = $random(seed);
		wr_reg(`ADDR_TTL_OUT, {24'h0, d[7:0]});
		rd_reg(`ADDR_TTL_OUT, v);
		check("line outputs", {v[7:0], ttl_oe}, {d[7:0], d[7:0]});
		wr_reg(`ADDR_TTL_OUT, 0);
		$display("test registers done");
		// disarmed command does nothing; front-panel input ignored while software armed
		wr_reg(`ADDR_CTRL, ctrl(SRC_SW, 0, 0, 0) & ~32'h20);
		wr_reg(`ADDR_CMD, 1);
		expect_start("disarmed", -1);
		wr_reg(`ADDR_CTRL, ctrl(SRC_SW, 0, 0, 0));
		pin(0, 1'b1);
		expect_start("ext ignored", -1);
		pin(0, 1'b0);
		expect_start("ext ignored", -1);
		for (i = 0; i < 9; i++) begin
			den = (i != 0);
			tm = !i[0];
			v = (i < 5) ? dly_tab(i) : (tm ? 5 + {$random(seed)} % 60 : 10 + {$random(seed)} % 40);
			lag = 4'($random(seed));
			wr_reg(`ADDR_DLY_CYC, v);
			wr_reg(`ADDR_DLY_TIME, v);
			wr_reg(`ADDR_CTRL, ctrl(SRC_SW, 0, den, tm));
			wr_reg(`ADDR_CMD, 1);
			expect_start("sw delay", dly_cyc(den, tm, v));
		end
		$display("test software and delay done");
		for (i = 0; i < 4; i++) begin
			wr_reg(`ADDR_TTL_IN, i[1] ? 32'h100 : 32'h0);
			wr_reg(`ADDR_CTRL, ctrl(i[1] ? SRC_BP : SRC_EXT, i[0], 0, 0));
			pin(i[1], 1'b1);
			expect_start("pin rise", i[0] ? -1 : -2);
			pin(i[1], 1'b0);
			expect_start("pin fall", i[0] ? -2 : -1);
		end
		$display("test front and ecl done");
		wr_reg(`ADDR_TTL_IN, 32'h08);
		wr_reg(`ADDR_CTRL, ctrl(SRC_BP, 0, 0, 0));
		for (i = 0; i < 2; i++) begin
			pin(7, 1'b0);
			expect_start("line5 fall", i ? -2 : -1);
			pin(7, 1'b1);
			expect_start("line5 rise", -1);
			wr_reg(`ADDR_TTL_IN, 32'h28);
		end
		wr_reg(`ADDR_CTRL, ctrl(SRC_BP, 1, 0, 0));
		wr_reg(`ADDR_TTL_OUT, 32'h08);
		mk_rand = 1'b1;
		expect_start("own line", -1);
		mk_rand = 1'b0;
		// let the last marker edge clear the synchroniser while the line is still masked
		repeat (8) @(negedge sys_clk);
		wr_reg(`ADDR_TTL_OUT, 0);
		pin(5, 1'b0);
		expect_start("line3 fall", -1);
		pin(5, 1'b1);
		expect_start("line3 rise", -2);
		rd_reg(`ADDR_TRIG_CNT, d);
		check("trigger count", d, exp_cnt);
		$display("test backplane done");
		wr_reg(`ADDR_INT_PERIOD, 2);
		wr_reg(`ADDR_CTRL, ctrl(SRC_INT, 0, 0, 0));
		expect_start("internal 1", -2);
		expect_start("internal 2", -2);
		$display("test internal done");
		summarize();
	end

	// fixed delay corners: off, cycle 0, time 100 ns, cycle 10, time 140 ns
	function automatic int dly_tab(input int k);
		int tab [5] = '{0, 0, 5, 10, 7};
		return tab[k];
	endfunction : dly_tab
endmodule : test_trig_front

/* bench/trig_partner.sv */
// far-side model: backplane instruments, internal generator clock and waveform engine
`timescale 1ns/1ps
module trig_partner (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] bp_drv_i,
	input  wire logic [7:0] dut_ttl_i,
	input  wire logic [7:0] dut_oe_i,
	input  wire logic       running_i,
	input  wire logic [3:0] lag_i,
	output logic      [7:0] ttl_o,
	output logic            int_clk_o,
	output logic            cycle_done_o
);
	logic [3:0] run_cnt_ff;

	// ======================================================================
	// backplane wire: the other instruments let go of a line the device drives
	assign ttl_o = (dut_oe_i & dut_ttl_i) | (~dut_oe_i & bp_drv_i);

	// free-running generator clock, 230 ns, never in step with the sample clock
	initial int_clk_o = 1'b0;
	always #115 int_clk_o = ~int_clk_o;

	// waveform engine: cycle_done_o pulses lag_i + 1 clocks after running rises
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_cnt_ff   <= 4'h0;
			cycle_done_o <= 1'b0;
		end else begin
			cycle_done_o <= running_i && !cycle_done_o && run_cnt_ff == lag_i;
			run_cnt_ff   <= running_i ? run_cnt_ff + 4'h1 : 4'h0;
		end
	end
endmodule : trig_partner

/* rtl/pin_sync.sv */
// three-stage synchroniser bank with agreement filter for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 11
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	// ======================================================================
	// per-bit chain; stage one feeds stage two only
	genvar gi;
	for (gi = 0; gi < WIDTH; gi++) begin : g_bit
		logic s1_ff;
		logic s2_ff;
		logic s3_ff;
		logic q_ff;
		always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				s1_ff <= 1'b0;
				s2_ff <= 1'b0;
				s3_ff <= 1'b0;
				q_ff  <= 1'b0;
			end else begin
				s1_ff <= d_i[gi];
				s2_ff <= s1_ff;
				s3_ff <= s2_ff;
				// a change counts only once two late stages agree
				if (s2_ff == s3_ff) begin
					q_ff <= s3_ff;
				end
			end
		end
		assign q_o[gi] = q_ff;
	end

endmodule : pin_sync

/* rtl/trig_front.sv */
// trigger source selection, edge polarity, trigger delay and backplane marker drive
// Function
// - only the selected source is armed; events from other sources are ignored
// - sources: front-panel input, internal generator, backplane lines, software command
// - software trigger command gives one trigger event when software source selected
// - internal generator clock is asynchronous and is brought safely into sample clock
// - each internal period expiry is a trigger; software keeps period above waveform's
// - any subset of backplane lines 0..7 may be inputs; any enabled line triggers
// - a backplane line driven as output never acts as trigger input
// - polarity applies to front-panel input, backplane lines 0..7 and ECL line 0
// - positive: front and ECL rise, backplane falls; negative is the reverse
// - front-panel edge counts only when it crosses the threshold in right direction
// - enabled delay sits between accepted trigger and waveform start
// - cycle delay: zero means none, 10 to 2M gives that many sample periods
// - delay enabled adds at least 100 ns; disabled adds nothing
// - time delay settable 100 ns to 20 s in 20 ns steps
// - output-configured backplane line carries marker, also on front-panel marker output
// - clearing output configuration releases the line for use as input again
// - each accepted trigger starts one waveform cycle, then output holds first point
`timescale 1ns/1ps
`include "trig_params.svh"
module trig_front
	import trig_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire logic        ext_trig_i,
	input  wire logic        ecl_trig_i,
	input  wire logic [7:0]  ttl_i,
	input  wire logic        int_clk_i,
	input  wire logic        marker_i,
	input  wire logic        cycle_done_i,
	output logic             start_o,
	output logic             running_o,
	output logic      [7:0]  ttl_o,
	output logic      [7:0]  ttl_oe_o,
	output logic             sync_out_o
);

	// ======================================================================
	// registers
	logic [5:0]  ctrl_ff;
	logic [8:0]  ttl_in_ff;
	logic [7:0]  ttl_out_ff;
	logic [23:0] int_period_ff;
	logic [23:0] dly_cyc_ff;
	logic [31:0] dly_time_ff;
	logic [15:0] trig_cnt_ff;
	logic [31:0] rdata_ff;
	logic [10:0] prev_ff;
	logic [23:0] int_cnt_ff;
	logic        int_ev_ff;
	logic [35:0] elapsed_ff;
	logic [35:0] target_ff;
	logic        start_ff;
	logic        marker_ff;
	state_t      state_ff;
	state_t      nxt_state;

	// ======================================================================
	// bus decode
	wire wr_ctrl   = wr_i && (addr_i == `ADDR_CTRL);
	wire wr_ttl_in = wr_i && (addr_i == `ADDR_TTL_IN);
	wire wr_ttl_o  = wr_i && (addr_i == `ADDR_TTL_OUT);
	wire wr_per    = wr_i && (addr_i == `ADDR_INT_PERIOD);
	wire wr_cyc    = wr_i && (addr_i == `ADDR_DLY_CYC);
	wire wr_time   = wr_i && (addr_i == `ADDR_DLY_TIME);
	wire wr_cmd    = wr_i && (addr_i == `ADDR_CMD);

	src_t      src_sel;
	assign src_sel = src_t'(ctrl_ff[`CTRL_SRC_MSB:`CTRL_SRC_LSB]);
	wire       slope_neg = ctrl_ff[`CTRL_SLOPE_NEG];
	wire       dly_en    = ctrl_ff[`CTRL_DLY_EN];
	wire       dly_time  = ctrl_ff[`CTRL_DLY_TIME];
	wire       armed     = ctrl_ff[`CTRL_ARM];

	// ======================================================================
	// pin synchronisers: ttl 7..0, front 8, ecl 9, internal clock 10
	logic [10:0] pin_q;
	pin_sync #(.WIDTH(11)) u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.d_i       ({int_clk_i, ecl_trig_i, ext_trig_i, ttl_i}),
		.q_o       (pin_q)
	);

	// edge detection only on synchronised levels
	wire [10:0] rise = pin_q & ~prev_ff;
	wire [10:0] fall = ~pin_q & prev_ff;

	// front input is a comparator output, so an edge already means a threshold crossing
	wire ext_ev  = slope_neg ? fall[8] : rise[8];
	wire ecl_ev  = ttl_in_ff[`TTL_IN_ECL] && (slope_neg ? fall[9] : rise[9]);
	// backplane lines use reversed sense; driven lines are masked off
	wire [7:0] ttl_eff = ttl_in_ff[7:0] & ~ttl_out_ff;
	wire [7:0] ttl_edg = slope_neg ? rise[7:0] : fall[7:0];
	wire ttl_ev  = |(ttl_eff & ttl_edg);
	wire bp_ev   = ttl_ev || ecl_ev;
	wire sw_ev   = wr_cmd && wdata_i[`CMD_SW_TRIG];

	// ======================================================================
	// source multiplexer: exactly one source reaches the sequencer
	wire ev_sel = (src_sel == SRC_EXT) ? ext_ev :
	              (src_sel == SRC_INT) ? int_ev_ff :
	              (src_sel == SRC_BP)  ? bp_ev : sw_ev;
	wire trig_hit = ev_sel && armed && (state_ff == ST_IDLE);

	// ======================================================================
	// internal generator: counts synchronised edges of its own clock
	wire [23:0] per_eff  = (int_period_ff == 24'h000000) ? 24'h000001 : int_period_ff;
	wire [23:0] int_next = int_cnt_ff + 24'h000001;
	wire        int_exp  = rise[10] && (int_next >= per_eff);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_cnt_ff <= 24'h000000;
			int_ev_ff  <= 1'b0;
		end else begin
			int_ev_ff <= int_exp;
			if (int_exp) begin
				int_cnt_ff <= 24'h000000;
			end else if (rise[10]) begin
				int_cnt_ff <= int_next;
			end
		end
	end

	// ======================================================================
	// delay target in ns; computed once at trigger so later writes do not disturb it
	wire [23:0] cyc_clip = (dly_cyc_ff == 24'h000000) ? 24'h000000 :
	                       (dly_cyc_ff < `DLY_CYC_MIN) ? `DLY_CYC_MIN :
	                       (dly_cyc_ff > `DLY_CYC_MAX) ? `DLY_CYC_MAX : dly_cyc_ff;
	wire [35:0] cyc_ns   = {12'h000, cyc_clip} * `CLK_NS;
	wire [35:0] time_ns  = {4'h0, dly_time_ff} * `STEP_NS;
	wire [35:0] raw_ns   = dly_time ? time_ns : cyc_ns;
	wire [35:0] cap_ns   = (raw_ns > `MAX_DLY_NS) ? `MAX_DLY_NS : raw_ns;
	wire [35:0] tgt_ns   = (cap_ns < `MIN_DLY_NS) ? `MIN_DLY_NS : cap_ns;
	wire [35:0] el_next  = elapsed_ff + `CLK_NS;
	wire        dly_done = (state_ff == ST_DELAY) && (el_next >= target_ff);

	// ======================================================================
	// sequencer: idle, optional delay, one waveform cycle
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (trig_hit) begin
					nxt_state = dly_en ? ST_DELAY : ST_RUN;
				end
			end
			ST_DELAY: begin
				if (dly_done) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (cycle_done_i) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	wire go_start = (trig_hit && !dly_en) || dly_done;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff   <= ST_IDLE;
			start_ff   <= 1'b0;
			elapsed_ff <= 36'h000000000;
			target_ff  <= 36'h000000000;
			prev_ff    <= 11'h000;
			marker_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			start_ff   <= go_start;
			elapsed_ff <= (state_ff == ST_DELAY) ? el_next : 36'h000000000;
			if (trig_hit) begin
				target_ff <= tgt_ns;
			end
			prev_ff    <= pin_q;
			marker_ff  <= marker_i;
		end
	end

	// ======================================================================
	// register writes and trigger counter
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_ff       <= `RST_CTRL;
			ttl_in_ff     <= `RST_TTL_IN;
			ttl_out_ff    <= `RST_TTL_OUT;
			int_period_ff <= `RST_INT_PERIOD;
			dly_cyc_ff    <= `RST_DLY_CYC;
			dly_time_ff   <= `RST_DLY_TIME;
			trig_cnt_ff   <= 16'h0000;
		end else begin
			if (wr_ctrl)   ctrl_ff       <= wdata_i[`CTRL_W-1:0];
			if (wr_ttl_in) ttl_in_ff     <= wdata_i[8:0];
			if (wr_ttl_o)  ttl_out_ff    <= wdata_i[7:0];
			if (wr_per)    int_period_ff <= wdata_i[23:0];
			if (wr_cyc)    dly_cyc_ff    <= wdata_i[23:0];
			if (wr_time)   dly_time_ff   <= wdata_i;
			if (trig_hit)  trig_cnt_ff   <= trig_cnt_ff + 16'h0001;
		end
	end

	// ======================================================================
	// read mux; unmapped addresses read zero
	wire [31:0] status_w = {24'h000000, marker_ff, pin_q[9:8], state_ff, armed, 1'b0};
	wire [31:0] rd_mux =
		(addr_i == `ADDR_CTRL)       ? {26'h0, ctrl_ff}     :
		(addr_i == `ADDR_TTL_IN)     ? {23'h0, ttl_in_ff}   :
		(addr_i == `ADDR_TTL_OUT)    ? {24'h0, ttl_out_ff}  :
		(addr_i == `ADDR_INT_PERIOD) ? {8'h00, int_period_ff} :
		(addr_i == `ADDR_DLY_CYC)    ? {8'h00, dly_cyc_ff}  :
		(addr_i == `ADDR_DLY_TIME)   ? dly_time_ff          :
		(addr_i == `ADDR_STATUS)     ? status_w             :
		(addr_i == `ADDR_TRIG_CNT)   ? {16'h0, trig_cnt_ff} : 32'h00000000;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_ff <= 32'h00000000;
		end else begin
			rdata_ff <= rd_i ? rd_mux : 32'h00000000;
		end
	end

	// ======================================================================
	// outputs, all straight from flops; the oe flop is the software register itself
	assign rdata_o    = rdata_ff;
	assign start_o    = start_ff;
	assign running_o  = state_ff[2];                                 // one-hot run bit
	assign ttl_o      = {8{marker_ff}};
	assign ttl_oe_o   = ttl_out_ff;
	assign sync_out_o = marker_ff;

	// ======================================================================
	// checks
	localparam int DLY_MIN_START = 4;

	foreign_ignored_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_ff == ST_IDLE && !ev_sel) |=> (state_ff == ST_IDLE && !start_ff))
		else $error("idle sequencer moved without a selected-source event");

	sw_trigger_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_ff == ST_IDLE && armed && src_sel == SRC_SW && sw_ev && !dly_en)
		|=> start_ff ##1 !start_ff)
		else $error("software trigger did not give one start pulse");

	out_mask_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(src_sel == SRC_BP && state_ff == ST_IDLE && armed && !ecl_ev &&
		!(|(ttl_in_ff[7:0] & ~ttl_oe_o & (slope_neg ? rise[7:0] : fall[7:0]))))
		|=> !start_ff && state_ff == ST_IDLE)
		else $error("backplane event accepted without an enabled input edge");

	marker_drive_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$past(rst_n_i) |-> ttl_o == {8{sync_out_o}} && sync_out_o == $past(marker_i))
		else $error("marker not on backplane and front outputs");

	release_line_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_ttl_o |=> ttl_oe_o == $past(wdata_i[7:0]))
		else $error("line output enable did not follow software");

	delay_min_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(trig_hit && dly_en) |=> (!start_ff && state_ff == ST_DELAY) [*3])
		else $error("delayed trigger started before 100 ns");

	no_delay_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(trig_hit && !dly_en) |=> start_ff && state_ff == ST_RUN)
		else $error("undelayed trigger did not start at once");

	delay_end_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(trig_hit && dly_en && tgt_ns == `MIN_DLY_NS) |-> ##DLY_MIN_START
		(start_ff && state_ff == ST_RUN))
		else $error("shortest delay did not end in a start after four cycles");

	one_cycle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_ff == ST_RUN && !cycle_done_i) |=> (state_ff == ST_RUN && !start_ff))
		else $error("second start inside one waveform cycle");

	int_event_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		int_ev_ff |-> $past(rise[10]) && int_cnt_ff == 24'h000000)
		else $error("internal event without period expiry");

	sw_start_c:  cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		src_sel == SRC_SW && trig_hit ##1 start_ff);
	delay_run_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		state_ff == ST_DELAY ##1 start_ff);
	ttl_trig_c:  cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		src_sel == SRC_BP && trig_hit);
	int_trig_c:  cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		src_sel == SRC_INT && trig_hit);

endmodule : trig_front

/* rtl/trig_params.svh */
// register map, field positions, reset values and timing counts of the trigger front end
`ifndef TRIG_PARAMS_SVH
`define TRIG_PARAMS_SVH

// ==========================================================================
// register offsets (byte addresses)
`define ADDR_CTRL        8'h00
`define ADDR_TTL_IN      8'h04
`define ADDR_TTL_OUT     8'h08
`define ADDR_INT_PERIOD  8'h0C
`define ADDR_DLY_CYC     8'h10
`define ADDR_DLY_TIME    8'h14
`define ADDR_CMD         8'h18
`define ADDR_STATUS      8'h1C
`define ADDR_TRIG_CNT    8'h20

// ==========================================================================
// control fields
`define CTRL_SRC_LSB     0
`define CTRL_SRC_MSB     1
`define CTRL_SLOPE_NEG   2
`define CTRL_DLY_EN      3
`define CTRL_DLY_TIME    4
`define CTRL_ARM         5
`define CTRL_W           6
`define TTL_IN_ECL       8
`define CMD_SW_TRIG      0

// ==========================================================================
// reset values
`define RST_CTRL         6'h00
`define RST_TTL_IN       9'h000
`define RST_TTL_OUT      8'h00
`define RST_INT_PERIOD   24'h000064
`define RST_DLY_CYC      24'h000000
`define RST_DLY_TIME     32'h00000005

// ==========================================================================
// timing, all delay arithmetic in nanoseconds
`define CLK_NS           36'd40
`define STEP_NS          36'd20
`define MIN_DLY_NS       36'd100
`define MAX_DLY_NS       36'd20000000000
`define DLY_CYC_MIN      24'd10
`define DLY_CYC_MAX      24'd2000000

`endif

/* rtl/trig_pkg.sv */
// types shared by the trigger front end
package trig_pkg;

	// ======================================================================
	// trigger source selection
	typedef enum logic [1:0] {
		SRC_EXT = 2'h0,
		SRC_INT = 2'h1,
		SRC_BP  = 2'h2,
		SRC_SW  = 2'h3
	} src_t;

	// ======================================================================
	// trigger sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_DELAY = 3'h2,
		ST_RUN   = 3'h4
	} state_t;

endpackage : trig_pkg
